// *** core/irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module irq_ctrl #(
  parameter int NUM_SRC = 6
) (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  // Register port
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [7:0]                 o_rdata,
  // Interrupt sources
  input  wire logic                  i_ext_irq_pin_a_n,
  input  wire logic                  i_ext_irq_pin_b_n,
  input  wire logic                  i_timer_a_req,
  input  wire logic                  i_timer_b_req,
  input  wire logic                  i_timer_c_req,
  input  wire logic                  i_serial_req,
  // CPU request and return
  output logic                       o_irq_valid,
  output irq_ctrl_pkg::vector_t      o_irq_vector,
  output irq_ctrl_pkg::prio_level_t  o_irq_level,
  input  wire logic                  i_irq_ack,
  input  wire logic                  i_return_from_interrupt,
  // Power control
  output logic                       o_cpu_run,
  output logic                       o_osc_run,
  output logic                       o_hold_pins,
  output logic                       o_ale_high,
  output logic                       o_program_store_enable_high
);
  import irq_ctrl_pkg::*;

  // Elaboration check
  if (NUM_SRC != 6) begin : g_bad_src
    $error("irq_ctrl serves exactly six sources");
  end

  // ********************************************
  // Helper functions
  // ********************************************

  // Best pending source; lower index wins a tie
  function automatic logic [5:0] pick_best(input logic [NUM_SRC-1:0] pend,
                                           input logic [7:0] hi, input logic [7:0] lo);
    logic    found;
    vector_t idx;
    prio_level_t lvl;
    found = 1'b0;
    idx   = 3'h0;
    lvl   = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!found || {hi[i], lo[i]} >= lvl)) begin
        found = 1'b1;
        idx   = 3'(i);
        lvl   = {hi[i], lo[i]};
      end
    end
    return {found, idx, lvl};
  endfunction

  // Highest level now in service
  function automatic logic [2:0] top_level(input logic [3:0] svc);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (svc[i]) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // ********************************************
  // State
  // ********************************************
  logic [7:0]   prio_low_reg;
  logic [7:0]   prio_high_reg;
  logic [7:0]   enable_reg;
  logic [1:0]   ext_mode_reg;
  logic [1:0]   ext_flag_reg;
  logic [1:0]   pin_prev_reg;
  logic [1:0]   pd_seen_reg;
  logic [3:0]   in_service_reg;
  logic         flag_a_reg;
  logic         flag_b_reg;
  power_state_t state_reg;
  power_state_t state_next;

  logic [1:0]          pin_low;
  logic [1:0]          pin_fall;
  logic [1:0]          pin_rise;
  logic [1:0]          ext_en;
  logic [NUM_SRC-1:0]  pend;
  logic [NUM_SRC-1:0]  pend_en;
  logic [5:0]          best;
  logic [2:0]          cur;
  logic                best_found;
  vector_t             best_idx;
  prio_level_t         best_lvl;
  logic                preempt_ok;
  logic                valid_next;
  logic                wake_any;
  logic                pwr_wr;
  logic                pd_release;
  logic [1:0]          ack_ext;

  // ********************************************
  // Source gathering and arbitration
  // ********************************************

  // Pin conditioning
  assign pin_low  = {~i_ext_irq_pin_b_n, ~i_ext_irq_pin_a_n};
  assign pin_fall = pin_low & ~pin_prev_reg;
  assign pin_rise = ~pin_low & pin_prev_reg;
  assign ext_en   = {enable_reg[`SRC_EXT_B], enable_reg[`SRC_EXT_A]};

  // Pending vector in grant order
  assign pend = {i_timer_c_req, i_serial_req, i_timer_b_req,
                 ext_flag_reg[1] | (~ext_mode_reg[1] & pin_low[1]),
                 i_timer_a_req,
                 ext_flag_reg[0] | (~ext_mode_reg[0] & pin_low[0])};

  // Enable gating
  assign pend_en = pend & enable_reg[NUM_SRC-1:0] & {NUM_SRC{enable_reg[`ENABLE_GLOBAL_BIT]}};

  // Priority resolution
  assign best       = pick_best(pend_en, prio_high_reg, prio_low_reg);
  assign best_found = best[5];
  assign best_idx   = best[4:2];
  assign best_lvl   = best[1:0];
  assign cur        = top_level(in_service_reg);
  assign preempt_ok = !cur[2] || (best_lvl > cur[1:0]);
  assign valid_next = best_found && preempt_ok && (state_reg == PWR_RUN) && !i_irq_ack;
  assign wake_any   = |pend_en;
  assign ack_ext    = {o_irq_valid && i_irq_ack && o_irq_vector == 3'(`SRC_EXT_B),
                       o_irq_valid && i_irq_ack && o_irq_vector == 3'(`SRC_EXT_A)};

  // Request outputs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_irq_valid  <= 1'b0;
      o_irq_vector <= 3'h0;
      o_irq_level  <= 2'h0;
    end else begin
      o_irq_valid  <= valid_next;
      o_irq_vector <= best_idx;
      o_irq_level  <= best_lvl;
    end
  end

  // In-service levels, pushed on ack, popped on return
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      in_service_reg <= 4'h0;
    end else begin
      if (i_return_from_interrupt && cur[2]) begin
        in_service_reg[cur[1:0]] <= 1'b0;
      end
      if (o_irq_valid && i_irq_ack) begin
        in_service_reg[o_irq_level] <= 1'b1;
      end
    end
  end

  // Pin history
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pin_prev_reg <= 2'h0;
    end else begin
      pin_prev_reg <= pin_low;
    end
  end

  // External flags; a set beats a clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ext_flag_reg <= 2'h0;
    end else begin
      ext_flag_reg <= (ext_flag_reg & ~ack_ext) | (pin_fall & ext_mode_reg)
                      | ({2{pd_release}} & pd_seen_reg & ext_en);
    end
  end

  // ********************************************
  // Register port
  // ********************************************
  assign pwr_wr = i_wr && (i_addr == `POWER_CTRL_ADDR);

  // Priority and enable registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      prio_low_reg  <= `PRIO_RESET;
      prio_high_reg <= `PRIO_RESET;
      enable_reg    <= `ENABLE_RESET;
      ext_mode_reg  <= `EXT_MODE_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `PRIO_LOW_ADDR:  prio_low_reg  <= i_wdata & `PRIO_USED_MASK;
        `PRIO_HIGH_ADDR: prio_high_reg <= i_wdata & `PRIO_USED_MASK;
        `ENABLE_ADDR:    enable_reg    <= i_wdata;
        `EXT_MODE_ADDR:  ext_mode_reg  <= i_wdata[1:0];
        default:         ;
      endcase
    end
  end

  // General flags
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else if (pwr_wr) begin
      flag_a_reg <= i_wdata[`PWR_FLAG_A_BIT];
      flag_b_reg <= i_wdata[`PWR_FLAG_B_BIT];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `PRIO_LOW_ADDR:   o_rdata <= prio_low_reg;
        `PRIO_HIGH_ADDR:  o_rdata <= prio_high_reg;
        `ENABLE_ADDR:     o_rdata <= enable_reg;
        `EXT_MODE_ADDR:   o_rdata <= {4'h0, ext_flag_reg, ext_mode_reg};
        `IN_SERVICE_ADDR: o_rdata <= {4'h0, in_service_reg};
        `POWER_CTRL_ADDR: o_rdata <= {4'h0, flag_b_reg, flag_a_reg,
                                      state_reg == PWR_DOWN || state_reg == PWR_RESTART,
                                      state_reg == PWR_IDLE};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ********************************************
  // Idle and power-down sequencing
  // ********************************************

  // Exit completes on first release of a pin seen low
  assign pd_release = (state_reg == PWR_RESTART) && |(pin_rise & pd_seen_reg);

  // Next power state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWR_RUN: begin
        if (pwr_wr && i_wdata[`PWR_DOWN_BIT]) begin
          state_next = PWR_DOWN;
        end else if (pwr_wr && i_wdata[`PWR_IDLE_BIT]) begin
          state_next = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (wake_any) begin
          state_next = PWR_RUN;
        end
      end
      PWR_DOWN: begin
        if (|(pin_low & ext_en) && enable_reg[`ENABLE_GLOBAL_BIT]) begin
          state_next = PWR_RESTART;
        end
      end
      PWR_RESTART: begin
        if (pd_release) begin
          state_next = PWR_RUN;
        end
      end
      default: state_next = PWR_RUN;
    endcase
  end

  // Power state register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg <= PWR_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pins seen low while powered down
  always_ff @(posedge i_mclk) begin
    if (i_reset || state_reg == PWR_RUN || state_reg == PWR_IDLE) begin
      pd_seen_reg <= 2'h0;
    end else begin
      pd_seen_reg <= pd_seen_reg | (pin_low & ext_en);
    end
  end

  // Gating outputs; CPU state frozen, nothing reset on entry
  assign o_cpu_run  = (state_reg == PWR_RUN);
  assign o_osc_run  = (state_reg != PWR_DOWN);
  assign o_hold_pins = (state_reg != PWR_RUN);
  assign o_ale_high  = (state_reg != PWR_RUN);
  assign o_program_store_enable_high = (state_reg != PWR_RUN);

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_enable_gates_src: assert property (valid_next |-> enable_reg[best_idx])
    else $error("disabled source forwarded");
  a_global_gate: assert property (o_irq_valid |-> $past(enable_reg[`ENABLE_GLOBAL_BIT]))
    else $error("request while global enable clear");
  a_level_compose: assert property (valid_next |->
      best_lvl == {prio_high_reg[best_idx], prio_low_reg[best_idx]})
    else $error("level not formed from high and low bits");
  a_strict_preempt: assert property (o_irq_valid && i_irq_ack && cur[2] |-> o_irq_level > cur[1:0])
    else $error("preemption by equal or lower level");
  a_prio_low_write: assert property (i_wr && i_addr == `PRIO_LOW_ADDR
      |=> prio_low_reg[5:0] == $past(i_wdata[5:0]))
    else $error("low priority bits not stored");
  a_reserved_zero: assert property (i_rd && i_addr == `PRIO_LOW_ADDR |=> o_rdata[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  a_idle_entry: assert property (state_reg == PWR_RUN && pwr_wr && i_wdata[1:0] == 2'h1
      |=> !o_cpu_run && o_ale_high && o_osc_run)
    else $error("idle not entered after request");
  a_idle_wake: assert property (state_reg == PWR_IDLE && wake_any |=> o_cpu_run ##1 o_irq_valid)
    else $error("idle not ended by enabled interrupt");
  a_pd_restart: assert property (state_reg == PWR_DOWN && |(pin_low & ext_en)
      && enable_reg[`ENABLE_GLOBAL_BIT] |=> o_osc_run && !o_cpu_run)
    else $error("oscillator not restarted");
  a_tie_order: assert property (valid_next && pend_en[0]
      && {prio_high_reg[0], prio_low_reg[0]} == best_lvl |-> best_idx == 3'h0)
    else $error("tie not granted in fixed order");

  c_idle_wake: cover property (state_reg == PWR_IDLE ##1 state_reg == PWR_RUN);
  c_pd_exit: cover property (state_reg == PWR_RESTART ##1 state_reg == PWR_RUN);
  c_nested: cover property (o_irq_valid && i_irq_ack && cur[2]);
  c_both_pins: cover property (pd_release && pd_seen_reg == 2'h3);
  c_edge_pin: cover property (ext_flag_reg[0] && ack_ext[0]);

endmodule

`default_nettype wire

// *** core/irq_ctrl_pkg.sv ***
`default_nettype none

package irq_ctrl_pkg;
  // Power sequencing states
  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_DOWN, PWR_RESTART} power_state_t;
  // Four-level priority
  typedef logic [1:0] prio_level_t;
  // Vector number of a source
  typedef logic [2:0] vector_t;
endpackage

`default_nettype wire

// *** core/irq_ctrl_regs.svh ***
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ********************************************
// Register offsets
// ********************************************
`define PRIO_LOW_ADDR     8'hB8
`define PRIO_HIGH_ADDR    8'hB7
`define ENABLE_ADDR       8'hA8
`define POWER_CTRL_ADDR   8'h87
`define EXT_MODE_ADDR     8'h88
`define IN_SERVICE_ADDR   8'hB9

// ********************************************
// Field positions
// ********************************************
`define ENABLE_GLOBAL_BIT 7
`define PWR_IDLE_BIT      0
`define PWR_DOWN_BIT      1
`define PWR_FLAG_A_BIT    2
`define PWR_FLAG_B_BIT    3
`define SRC_EXT_A         0
`define SRC_EXT_B         2

// ********************************************
// Reset values and masks
// ********************************************
`define PRIO_RESET        8'h00
`define ENABLE_RESET      8'h00
`define EXT_MODE_RESET    2'h0
`define PRIO_USED_MASK    8'h3F

`endif

// *** verification/cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************
// CPU side of the request port
// ****************************
module cpu_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset,
  // Bench controls
  input  wire logic i_ack_en,
  input  wire logic i_slow,
  input  wire logic i_ret_cmd,
  // Controller side
  input  wire logic i_irq_valid,
  output logic      o_irq_ack,
  output logic      o_return_from_interrupt
);
  logic [1:0] wait_reg;

  // One ack per request, promptly or after three stalls
  always_ff @(posedge i_mclk) begin
    if (i_reset || !i_irq_valid || !i_ack_en || o_irq_ack) begin
      o_irq_ack <= 1'h0;
      wait_reg  <= 2'h0;
    end else if (wait_reg == (i_slow ? 2'h3 : 2'h0)) begin
      o_irq_ack <= 1'h1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  // Return pulse one cycle after the bench asks
  always_ff @(posedge i_mclk) begin
    o_return_from_interrupt <= !i_reset && i_ret_cmd;
  end
endmodule

`default_nettype wire

// *** verification/irq_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl_tb;
  import irq_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] plo;
    logic [7:0] phi;
    logic [5:0] src;
    logic       v;
    logic [1:0] lvl;
    logic [2:0] vec;
  } row_t;

  // ****************************
  // Signals and instances
  // ****************************
  logic        i_mclk, i_reset, i_wr, i_rd, ack_en, slow, ret_cmd;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic [5:0]  src;
  logic        o_irq_valid, i_irq_ack, i_return_from_interrupt;
  vector_t     o_irq_vector;
  prio_level_t o_irq_level;
  logic        o_cpu_run, o_osc_run, o_hold_pins, o_ale_high, o_program_store_enable_high;
  int          n_errors, tests_run;
  row_t        rows [10];
  // Source bits in vector order, pins active low
  wire         i_ext_irq_pin_a_n = ~src[0];
  wire         i_timer_a_req     = src[1];
  wire         i_ext_irq_pin_b_n = ~src[2];
  wire         i_timer_b_req     = src[3];
  wire         i_serial_req      = src[4];
  wire         i_timer_c_req     = src[5];

  irq_ctrl #(.NUM_SRC(6)) u_dut (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ext_irq_pin_a_n, .i_ext_irq_pin_b_n, .i_timer_a_req, .i_timer_b_req, .i_timer_c_req,
    .i_serial_req, .o_irq_valid, .o_irq_vector, .o_irq_level, .i_irq_ack,
    .i_return_from_interrupt, .o_cpu_run, .o_osc_run, .o_hold_pins, .o_ale_high,
    .o_program_store_enable_high);
  cpu_model u_cpu (.i_mclk, .i_reset, .i_ack_en(ack_en), .i_slow(slow), .i_ret_cmd(ret_cmd),
    .i_irq_valid(o_irq_valid), .o_irq_ack(i_irq_ack),
    .o_return_from_interrupt(i_return_from_interrupt));

  // 10 MHz clock
  initial begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end

  // ****************************
  // Tasks
  // ****************************
  task end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'h1;
    @(posedge i_mclk);
    i_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'h1;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    @(negedge i_mclk);
    chk8(o_rdata & m, exp);
    @(posedge i_mclk);
  endtask
  task chk_req(input logic v, input logic [1:0] l, input logic [2:0] c);
    @(negedge i_mclk);
    chk8({2'h0, o_irq_valid, v ? o_irq_level : 2'h0, v ? o_irq_vector : 3'h0}, {2'h0, v, l, c});
    @(posedge i_mclk);
  endtask
  // Run, oscillator, pin hold, address strobe, store enable
  task chk_pwr(input logic [4:0] e);
    @(negedge i_mclk);
    chk8({3'h0, o_cpu_run, o_osc_run, o_hold_pins, o_ale_high, o_program_store_enable_high},
         {3'h0, e});
    @(posedge i_mclk);
  endtask
  task wait_run();
    int i;
    @(negedge i_mclk);
    for (i = 0; i < 8 && o_cpu_run !== 1'h1; i++) @(negedge i_mclk);
    if (i == 8) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, o_cpu_run, 1'h1);
      end_sim();
    end else @(posedge i_mclk);
  endtask
  task ret();
    @(posedge i_mclk);
    ret_cmd <= 1'h1;
    @(posedge i_mclk);
    ret_cmd <= 1'h0;
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    i_reset = 1'h1;
    {i_wr, i_rd, ack_en, slow, ret_cmd} = 5'h00;
    {i_addr, i_wdata, src} = 22'h0;
    n_errors = 0;
    tests_run = 0;
    rows = '{'{8'h3F, 8'h00, 8'h00, 6'h3F, 1'h0, 2'h0, 3'h0},
             '{8'h80, 8'h00, 8'h00, 6'h3F, 1'h0, 2'h0, 3'h0},
             '{8'hBF, 8'h00, 8'h00, 6'h3F, 1'h1, 2'h0, 3'h0},
             '{8'hBE, 8'h00, 8'h00, 6'h3E, 1'h1, 2'h0, 3'h1},
             '{8'hBF, 8'h20, 8'h20, 6'h3F, 1'h1, 2'h3, 3'h5},
             '{8'hBF, 8'h10, 8'h00, 6'h3F, 1'h1, 2'h1, 3'h4},
             '{8'hBF, 8'h00, 8'h08, 6'h3F, 1'h1, 2'h2, 3'h3},
             '{8'hBF, 8'h24, 8'h00, 6'h3F, 1'h1, 2'h1, 3'h2},
             '{8'hA0, 8'h00, 8'h00, 6'h1F, 1'h0, 2'h0, 3'h0},
             '{8'hBF, 8'h3F, 8'h3F, 6'h30, 1'h1, 2'h3, 3'h4}};
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'h0;
    rd(8'hB8, 8'hFF, 8'h00);
    rd(8'hA8, 8'hFF, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'hFF, 8'h00);
    wr(8'hB8, 8'h3F);
    rd(8'hB8, 8'hFF, 8'h3F);
    // Enable, level and tie order table
    foreach (rows[k]) begin
      wr(8'hA8, rows[k].en);
      wr(8'hB8, rows[k].plo);
      wr(8'hB7, rows[k].phi);
      src <= rows[k].src;
      cyc(2);
      chk_req(rows[k].v, rows[k].lvl, rows[k].vec);
      src <= 6'h00;
      cyc(2);
    end
    // Nesting: equal level waits, higher level preempts
    wr(8'hA8, 8'hBF);
    wr(8'hB8, 8'h0A);
    wr(8'hB7, 8'h10);
    ack_en <= 1'h1;
    src <= 6'h02;
    cyc(6);
    rd(8'hB9, 8'h0F, 8'h02);
    src <= 6'h08;
    cyc(3);
    chk_req(1'h0, 2'h0, 3'h0);
    slow <= 1'h1;
    src <= 6'h18;
    cyc(2);
    chk_req(1'h1, 2'h2, 3'h4);
    cyc(6);
    rd(8'hB9, 8'h0F, 8'h06);
    src <= 6'h08;
    ret();
    cyc(2);
    rd(8'hB9, 8'h0F, 8'h02);
    ack_en <= 1'h0;
    ret();
    cyc(3);
    chk_req(1'h1, 2'h1, 3'h3);
    src <= 6'h00;
    slow <= 1'h0;
    cyc(2);
    // Idle entry, disabled source ignored, enabled source wakes
    wr(8'hB8, 8'h00);
    wr(8'hB7, 8'h00);
    wr(8'hA8, 8'h9F);
    wr(8'h87, 8'h0D);
    chk_pwr(5'h0F);
    src <= 6'h20;
    cyc(4);
    chk_pwr(5'h0F);
    src <= 6'h22;
    wait_run();
    chk_req(1'h1, 2'h0, 3'h1);
    rd(8'h87, 8'h0F, 8'h0C);
    // Reset ends idle
    src <= 6'h00;
    cyc(2);
    wr(8'h87, 8'h01);
    chk_pwr(5'h0F);
    @(posedge i_mclk);
    i_reset <= 1'h1;
    cyc(2);
    i_reset <= 1'h0;
    chk_pwr(5'h18);
    rd(8'hA8, 8'hFF, 8'h00);
    // Edge-sensitive pin a: a one-cycle low pulse is latched, cleared on ack
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h81);
    src <= 6'h01;
    @(posedge i_mclk);
    src <= 6'h00;
    cyc(2);
    chk_req(1'h1, 2'h0, 3'h0);
    rd(8'h88, 8'h0F, 8'h05);
    ack_en <= 1'h1;
    cyc(4);
    ack_en <= 1'h0;
    rd(8'h88, 8'h0F, 8'h01);
    ret();
    wr(8'h88, 8'h00);
    // Power-down and pin wake
    wr(8'hA8, 8'h87);
    wr(8'hB8, 8'h01);
    wr(8'hB7, 8'h04);
    wr(8'h87, 8'h02);
    chk_pwr(5'h07);
    src <= 6'h02;
    cyc(3);
    chk_pwr(5'h07);
    src <= 6'h03;
    cyc(2);
    chk_pwr(5'h0F);
    src <= 6'h07;
    cyc(3);
    chk_pwr(5'h0F);
    src <= 6'h06;
    wait_run();
    chk_req(1'h1, 2'h2, 3'h2);
    rd(8'hB8, 8'hFF, 8'h01);
    end_sim();
  end
endmodule

`default_nettype wire
